//--- hw/pced_pkg.sv
// package: register map, field layout and types for the pin edge interrupt detector
package pced_pkg;
   localparam int unsigned PCED_PINS           = 6;
   localparam int unsigned PCED_ADDR_W         = 8;
   // register byte offsets
   localparam logic [7:0]  PCED_OFF_A_RISE     = 8'h00;
   localparam logic [7:0]  PCED_OFF_A_FALL     = 8'h04;
   localparam logic [7:0]  PCED_OFF_A_FLAGS    = 8'h08;
   localparam logic [7:0]  PCED_OFF_C_RISE     = 8'h0c;
   localparam logic [7:0]  PCED_OFF_C_FALL     = 8'h10;
   localparam logic [7:0]  PCED_OFF_C_FLAGS    = 8'h14;
   localparam logic [7:0]  PCED_OFF_CTRL       = 8'h18;
   localparam logic [7:0]  PCED_OFF_STATUS     = 8'h1c;
   // control register fields
   localparam int unsigned PCED_CTRL_IRQ_EN    = 0;
   localparam int unsigned PCED_CTRL_MOD_OFF   = 1;
   localparam int unsigned PCED_CTRL_SLEEP     = 2;
   // status register fields
   localparam int unsigned PCED_STAT_SUMMARY   = 0;
   localparam int unsigned PCED_STAT_IRQ       = 1;
   localparam int unsigned PCED_STAT_WAKE      = 2;
   // reset values
   localparam logic [5:0]  PCED_RST_PORT       = 6'h00;
   localparam logic [2:0]  PCED_RST_CTRL       = 3'h0;

   typedef logic [PCED_PINS-1:0] pced_pins_t;

   typedef struct packed {
      pced_pins_t rise;
      pced_pins_t fall;
      pced_pins_t flags;
   } pced_port_s;

   typedef struct packed {
      logic                   cyc;
      logic                   stb;
      logic                   we;
      logic [3:0]             sel;
      logic [PCED_ADDR_W-1:0] adr;
      logic [31:0]            dat;
   } pced_wb_req_s;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } pced_wb_rsp_s;
endpackage : pced_pkg

//--- hw/pced_top.sv
// pin edge interrupt detector with classic wishbone register slave
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module pced_top #(
   parameter bit HAS_PORTC = 1'b1
) (
   // clock and reset
   input  wire logic                  sys_clk_i,
   input  wire logic                  nrst_i,
   // pins
   input  wire pced_pkg::pced_pins_t  porta_pin_i,
   input  wire pced_pkg::pced_pins_t  portc_pin_i,
   // core state
   input  wire logic                  core_sleep_i,
   // wishbone slave
   input  wire pced_pkg::pced_wb_req_s wb_req_i,
   output logic                       wb_ack_o,
   output logic [31:0]                wb_dat_o,
   // core interrupt and wake
   output logic                       change_irq_o,
   output logic                       change_irq_summary_flag_o,
   output logic                       wake_o
);
   import pced_pkg::*;

   pced_pins_t a_sync1;
   pced_pins_t a_sync2;
   pced_pins_t a_prev;
   pced_pins_t c_sync1;
   pced_pins_t c_sync2;
   pced_pins_t c_prev;
   logic       sleep_sync1;
   logic       sleep_sync2;
   pced_port_s porta;
   pced_port_s portc;
   logic       change_irq_global_enable;
   logic       change_detector_module_off;
   logic       prev_valid;
   logic       wb_hit;
   logic       wr_stb;
   pced_pins_t a_edge;
   pced_pins_t c_edge;
   logic       any_flag;
   logic [31:0] next_rdata;

   // edge detect for one port
   function automatic pced_pins_t edge_hits(input pced_pins_t cur, input pced_pins_t prev,
                                            input pced_pins_t rise, input pced_pins_t fall);
      edge_hits = (cur & ~prev & rise)
                | (~cur & prev & fall);
   endfunction : edge_hits

   // flag update: set wins over write clear
   function automatic pced_pins_t flag_next(input pced_pins_t cur, input pced_pins_t hits,
                                            input logic wr, input pced_pins_t wdata);
      flag_next = (wr ? (cur & wdata) : cur) | hits;
   endfunction : flag_next

   // synchronisers
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         a_sync1     <= PCED_RST_PORT;
         a_sync2     <= PCED_RST_PORT;
         c_sync1     <= PCED_RST_PORT;
         c_sync2     <= PCED_RST_PORT;
         sleep_sync1 <= 1'b0;
         sleep_sync2 <= 1'b0;
      end else begin
         a_sync1     <= porta_pin_i;
         a_sync2     <= a_sync1;
         c_sync1     <= portc_pin_i;
         c_sync2     <= c_sync1;
         sleep_sync1 <= core_sleep_i;
         sleep_sync2 <= sleep_sync1;
      end
   end

   // previous sample; invalid while off so no false edge at re-enable
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         a_prev     <= PCED_RST_PORT;
         c_prev     <= PCED_RST_PORT;
         prev_valid <= 1'b0;
      end else begin
         a_prev     <= a_sync2;
         c_prev     <= c_sync2;
         prev_valid <= !change_detector_module_off;
      end
   end

   always_comb begin
      a_edge = PCED_RST_PORT;
      c_edge = PCED_RST_PORT;
      if (prev_valid && !change_detector_module_off) begin
         a_edge = edge_hits(a_sync2, a_prev, porta.rise, porta.fall);
         if (HAS_PORTC) begin
            c_edge = edge_hits(c_sync2, c_prev, portc.rise, portc.fall);
         end
      end
   end

   assign wb_hit = wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
   // writes land at the edge that samples ack high
   assign wr_stb = wb_req_i.cyc && wb_req_i.stb && wb_ack_o && wb_req_i.we && wb_req_i.sel[0];

   // control register, never held by the module-off bit
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         change_irq_global_enable   <= PCED_RST_CTRL[PCED_CTRL_IRQ_EN];
         change_detector_module_off <= PCED_RST_CTRL[PCED_CTRL_MOD_OFF];
      end else if (wr_stb && wb_req_i.adr == PCED_OFF_CTRL) begin
         change_irq_global_enable   <= wb_req_i.dat[PCED_CTRL_IRQ_EN];
         change_detector_module_off <= wb_req_i.dat[PCED_CTRL_MOD_OFF];
      end
   end

   // port registers
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         porta <= '0;
         portc <= '0;
      end else if (change_detector_module_off) begin
         porta <= '0;
         portc <= '0;
      end else begin
         if (wr_stb && wb_req_i.adr == PCED_OFF_A_RISE) begin
            porta.rise <= wb_req_i.dat[PCED_PINS-1:0];
         end
         if (wr_stb && wb_req_i.adr == PCED_OFF_A_FALL) begin
            porta.fall <= wb_req_i.dat[PCED_PINS-1:0];
         end
         porta.flags <= flag_next(porta.flags, a_edge,
                                  wr_stb && wb_req_i.adr == PCED_OFF_A_FLAGS,
                                  wb_req_i.dat[PCED_PINS-1:0]);
         if (HAS_PORTC) begin
            if (wr_stb && wb_req_i.adr == PCED_OFF_C_RISE) begin
               portc.rise <= wb_req_i.dat[PCED_PINS-1:0];
            end
            if (wr_stb && wb_req_i.adr == PCED_OFF_C_FALL) begin
               portc.fall <= wb_req_i.dat[PCED_PINS-1:0];
            end
            portc.flags <= flag_next(portc.flags, c_edge,
                                     wr_stb && wb_req_i.adr == PCED_OFF_C_FLAGS,
                                     wb_req_i.dat[PCED_PINS-1:0]);
         end
      end
   end

   assign any_flag = |{porta.flags, portc.flags};

   // read mux
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (!change_detector_module_off || wb_req_i.adr == PCED_OFF_CTRL) begin
         unique case (wb_req_i.adr)
            PCED_OFF_A_RISE:  next_rdata[PCED_PINS-1:0] = porta.rise;
            PCED_OFF_A_FALL:  next_rdata[PCED_PINS-1:0] = porta.fall;
            PCED_OFF_A_FLAGS: next_rdata[PCED_PINS-1:0] = porta.flags;
            PCED_OFF_C_RISE:  next_rdata[PCED_PINS-1:0] = portc.rise;
            PCED_OFF_C_FALL:  next_rdata[PCED_PINS-1:0] = portc.fall;
            PCED_OFF_C_FLAGS: next_rdata[PCED_PINS-1:0] = portc.flags;
            PCED_OFF_CTRL: begin
               next_rdata[PCED_CTRL_IRQ_EN]  = change_irq_global_enable;
               next_rdata[PCED_CTRL_MOD_OFF] = change_detector_module_off;
               next_rdata[PCED_CTRL_SLEEP]   = sleep_sync2;
            end
            PCED_OFF_STATUS: begin
               next_rdata[PCED_STAT_SUMMARY] = change_irq_summary_flag_o;
               next_rdata[PCED_STAT_IRQ]     = change_irq_o;
               next_rdata[PCED_STAT_WAKE]    = wake_o;
            end
            default:          next_rdata = 32'h0000_0000;
         endcase
      end
   end

   // bus answer: one wait state, unmapped reads zero
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_hit;
         wb_dat_o <= wb_hit ? next_rdata : 32'h0000_0000;
      end
   end

   // interrupt, summary and wake outputs
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         change_irq_summary_flag_o <= 1'b0;
         change_irq_o              <= 1'b0;
         wake_o                    <= 1'b0;
      end else begin
         change_irq_summary_flag_o <= any_flag;
         change_irq_o              <= any_flag && change_irq_global_enable;
         wake_o                    <= any_flag && change_irq_global_enable
                                      && sleep_sync2;
      end
   end
endmodule : pced_top

//--- sim/pced_pin_model.sv
// partner: external pin drivers for ports a and c
`timescale 1ns/1ps
module pced_pin_model (
   // clock
   input  wire logic                 sys_clk_i,
   // requested pin levels
   input  wire pced_pkg::pced_pins_t a_next_i,
   input  wire pced_pkg::pced_pins_t c_next_i,
   // pins
   output pced_pkg::pced_pins_t      a_pin_o,
   output pced_pkg::pced_pins_t      c_pin_o
);
   import pced_pkg::*;
   always_ff @(posedge sys_clk_i) begin
      a_pin_o <= a_next_i;
      c_pin_o <= c_next_i;
   end
endmodule : pced_pin_model

//--- sim/pced_properties.sv
// checker: port-level properties of the pin edge detector
`timescale 1ns/1ps
module pced_checker (
   input wire logic                  sys_clk_i,
   input wire logic                  nrst_i,
   input wire pced_pkg::pced_pins_t  porta_pin_i,
   input wire pced_pkg::pced_pins_t  portc_pin_i,
   input wire pced_pkg::pced_wb_req_s wb_req_i,
   input wire logic                  wb_ack_o,
   input wire logic [31:0]           wb_dat_o,
   input wire logic                  change_irq_o,
   input wire logic                  change_irq_summary_flag_o,
   input wire logic                  wake_o
);
   import pced_pkg::*;
   logic [11:0] last_pins;
   logic [2:0]  quiet;
   // cycles since a pin last moved, saturating
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         last_pins <= 12'h000;
         quiet     <= 3'h7;
      end else begin
         last_pins <= {porta_pin_i, portc_pin_i};
         if ({porta_pin_i, portc_pin_i} != last_pins) quiet <= 3'h0;
         else if (quiet != 3'h7) quiet <= quiet + 3'h1;
      end
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_take;
      wb_req_i.cyc && wb_req_i.stb && !wb_ack_o;
   endsequence
   property p_ack_answer; s_take |=> wb_ack_o; endproperty
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   property p_upper_zero; wb_ack_o |-> wb_dat_o[31:6] == 26'h0; endproperty
   property p_irq_gated; change_irq_o |-> change_irq_summary_flag_o; endproperty
   property p_wake; wake_o |-> change_irq_o; endproperty
   property p_set_cause; $rose(change_irq_summary_flag_o) |-> quiet <= 3'h5; endproperty
   property p_clear_cause;
      $fell(change_irq_summary_flag_o) |-> wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2)
                                           || $past(wb_ack_o, 3);
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("ack missing after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_dat_idle: assert property (p_dat_idle) else $error("read data without ack");
   a_upper_zero: assert property (p_upper_zero) else $error("upper bits not zero");
   a_irq_gated: assert property (p_irq_gated) else $error("irq without flag");
   a_wake: assert property (p_wake) else $error("wake without irq");
   a_set_cause: assert property (p_set_cause) else $error("flag without edge");
   a_clear_cause: assert property (p_clear_cause) else $error("flag cleared alone");
endmodule : pced_checker
bind pced_top pced_checker chk_u (.sys_clk_i, .nrst_i, .porta_pin_i, .portc_pin_i, .wb_req_i,
   .wb_ack_o, .wb_dat_o, .change_irq_o, .change_irq_summary_flag_o, .wake_o);

//--- sim/pin_edge_interrupt_detector_bench.sv
// testbench: register, edge, sleep and module-off scenarios
`timescale 1ns/1ps
module pin_edge_interrupt_detector_bench;
   import pced_pkg::*;
   logic         sys_clk_i = 1'b0;
   logic         nrst_i    = 1'b0;
   logic         sleep     = 1'b0;
   pced_pins_t   pa_nx     = '0;
   pced_pins_t   pc_nx     = '0;
   pced_pins_t   pa, pc;
   pced_wb_req_s req       = '0;
   logic         ack, irq, sum, wake;
   logic [31:0]  dat, rd;
   int           fail_count = 0, tests_run = 0, cyc_n = 0;
   always #50 sys_clk_i = ~sys_clk_i;
   pced_pin_model pm_u (.sys_clk_i, .a_next_i(pa_nx), .c_next_i(pc_nx), .a_pin_o(pa),
      .c_pin_o(pc));
   pced_top dut_u (.sys_clk_i, .nrst_i, .porta_pin_i(pa), .portc_pin_i(pc), .core_sleep_i(sleep),
      .wb_req_i(req), .wb_ack_o(ack), .wb_dat_o(dat), .change_irq_o(irq),
      .change_irq_summary_flag_o(sum), .wake_o(wake));
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   always @(posedge sys_clk_i) begin
      cyc_n++;
      if (cyc_n == 3000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("BAD %s expected %h seen %h", nm, exp, got);
         fail_count++;
      end
   endtask : check
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: wd};
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = dat;
      check("ack", 32'h1, {31'h0, ack});
      req <= '0;
      @(posedge sys_clk_i);
   endtask : bus
   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      check(nm, exp, rd);
   endtask : rdc
   task automatic pins(input pced_pins_t a, input pced_pins_t c);
      pa_nx <= a;
      pc_nx <= c;
      repeat (7) @(posedge sys_clk_i);
   endtask : pins
   task automatic t_reset;
      for (int i = 0; i < 9; i++) rdc("reset", 8'(i * 4), 32'h0);
   endtask : t_reset
   task automatic t_port(input logic [7:0] b, input bit c);
      bus(1'b1, b, 32'hc5);
      rdc("rise", b, 32'h05);
      bus(1'b1, b + 8'h04, 32'h06);
      pins(c ? 6'h00 : 6'h3f, c ? 6'h3f : 6'h00);
      rdc("flags up", b + 8'h08, 32'h05);
      check("summary", 32'h1, {31'h0, sum});
      check("irq off", 32'h0, {31'h0, irq});
      pins(6'h00, 6'h00);
      rdc("flags down", b + 8'h08, 32'h07);
      bus(1'b1, PCED_OFF_CTRL, 32'h1);
      repeat (2) @(posedge sys_clk_i);
      check("irq on", 32'h1, {31'h0, irq});
      check("wake awake", 32'h0, {31'h0, wake});
      bus(1'b1, b + 8'h08, ~32'h07);
      rdc("cleared", b + 8'h08, 32'h0);
      bus(1'b1, PCED_OFF_CTRL, 32'h0);
   endtask : t_port
   task automatic t_race;
      pa_nx <= 6'h01;
      repeat (2) @(posedge sys_clk_i);
      bus(1'b1, PCED_OFF_A_FLAGS, 32'h0);
      rdc("set wins", PCED_OFF_A_FLAGS, 32'h01);
      bus(1'b1, PCED_OFF_A_FLAGS, 32'h0);
      pins(6'h00, 6'h00);
   endtask : t_race
   task automatic t_sleep;
      sleep <= 1'b1;
      bus(1'b1, PCED_OFF_CTRL, 32'h1);
      pins(6'h01, 6'h00);
      check("wake", 32'h1, {31'h0, wake});
      rdc("sleep flag", PCED_OFF_A_FLAGS, 32'h01);
      rdc("status", PCED_OFF_STATUS, 32'h07);
      rdc("ctrl sleep", PCED_OFF_CTRL, 32'h05);
      sleep <= 1'b0;
      bus(1'b1, PCED_OFF_A_FLAGS, 32'h0);
      pins(6'h00, 6'h00);
   endtask : t_sleep
   task automatic t_off;
      bus(1'b1, PCED_OFF_CTRL, 32'h2);
      bus(1'b1, PCED_OFF_A_FALL, 32'h3f);
      rdc("off read", PCED_OFF_A_FALL, 32'h0);
      pins(6'h00, 6'h3f);
      check("off summary", 32'h0, {31'h0, sum});
      bus(1'b1, PCED_OFF_CTRL, 32'h0);
      rdc("back rise", PCED_OFF_A_RISE, 32'h0);
   endtask : t_off
   initial begin
      repeat (5) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      @(posedge sys_clk_i);
      t_reset();
      t_port(PCED_OFF_A_RISE, 1'b0);
      t_port(PCED_OFF_C_RISE, 1'b1);
      t_race();
      t_sleep();
      t_off();
      give_verdict();
   end
endmodule : pin_edge_interrupt_detector_bench
